// ### rtl/tp_timer_cfg.sv
// Timer 1/2 configuration, pin routing and timer status, on AHB-Lite.
// Assumes timer 0 and the serial transmitter live elsewhere and are synchronous.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module tp_timer_cfg
  import tp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              timer0_output,
  input  wire logic              timer0_running_flag,
  input  wire logic              timer0_out_of_reset_flag,
  input  wire logic              serial_tx,
  input  wire logic [3:0]        gpio_a_out,
  input  wire logic [3:0]        gpio_a_oe,
  input  wire logic [3:0]        gpio_c_out,
  input  wire logic [3:0]        gpio_c_oe,
  output logic [3:0]             porta_pin_out,
  output logic [3:0]             porta_pin_oe,
  output logic [3:0]             portc_pin_out,
  output logic [3:0]             portc_pin_oe,
  output logic                   porta_width_8,
  output logic                   timer1_output,
  output logic                   timer2_output,
  output logic                   irq
);
  import tp_pkg::*;

  typedef struct packed {
    logic        dp_write;
    logic [7:0]  dp_index;
    logic [31:0] rdata;
    logic [7:0]  t1_ctrl;
    logic [7:0]  t1_clk;
    logic [7:0]  t2_ctrl;
    logic [7:0]  t2_clk;
    logic [7:0]  pa_func;
    logic [7:0]  pc_func;
    logic [7:0]  t1_cmp;
    logic [7:0]  t2_cmp;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
  } tp_cfg_s;

  tp_cfg_s     cfg_reg;
  tp_cfg_s     cfg_next;
  logic        addr_phase;
  logic [7:0]  a_index;
  logic [7:0]  rd_val;
  logic [1:0]  tmr_out;
  logic [1:0]  tmr_ev;
  logic [7:0]  tmr_ctrl [2];
  logic [7:0]  tmr_clk  [2];
  logic [7:0]  tmr_cmp  [2];
  logic [2:0]  tmr_all;

  ////////////////////////////////////////////////////////////////////////////
  // Timer units
  assign tmr_ctrl[0] = cfg_reg.t1_ctrl;
  assign tmr_ctrl[1] = cfg_reg.t2_ctrl;
  assign tmr_clk[0]  = cfg_reg.t1_clk;
  assign tmr_clk[1]  = cfg_reg.t2_clk;
  assign tmr_cmp[0]  = cfg_reg.t1_cmp;
  assign tmr_cmp[1]  = cfg_reg.t2_cmp;

  for (genvar g = 0; g < 2; g++) begin : g_tmr
    tp_timer_unit u_unit (
      .sys_clk         (sys_clk),
      .arst_n          (arst_n),
      .soft_reset_n    (tmr_ctrl[g][CTRL_RST_N]),
      .soft_run        (tmr_ctrl[g][CTRL_RUN]),
      .pwm_select      (tmr_ctrl[g][CTRL_PWM]),
      .square_wave_sel (tmr_clk[g][CLK_SQUARE]),
      .irq_edge_sel    (tmr_ctrl[g][CTRL_EDGE+1:CTRL_EDGE]),
      .irq_source_sel  (tmr_ctrl[g][CTRL_SRC]),
      .divider_code    (tmr_clk[g][CLK_DIV+4:CLK_DIV]),
      .compare         (tmr_cmp[g]),
      .timer_output    (tmr_out[g]),
      .irq_event       (tmr_ev[g])
    );
  end

  assign timer1_output = tmr_out[0];
  assign timer2_output = tmr_out[1];
  assign tmr_all       = {tmr_out[1], tmr_out[0], timer0_output};

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing; a routed timer pin floats while that timer is in reset
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic in_rst;
      in_rst = 1'b0;
      case (i)
        0:       in_rst = ~timer0_out_of_reset_flag;
        1:       in_rst = ~cfg_reg.t1_ctrl[CTRL_RST_N];
        default: in_rst = ~cfg_reg.t2_ctrl[CTRL_RST_N];
      endcase
      if (cfg_reg.pa_func[i]) begin
        porta_pin_out[i] = tmr_all[i];
        porta_pin_oe[i]  = ~in_rst;
      end else begin
        porta_pin_out[i] = gpio_a_out[i];
        porta_pin_oe[i]  = gpio_a_oe[i];
      end
      if (!cfg_reg.pc_func[i]) begin
        portc_pin_out[i] = tmr_all[i];
        portc_pin_oe[i]  = ~in_rst;
      end else begin
        portc_pin_out[i] = gpio_c_out[i];
        portc_pin_oe[i]  = gpio_c_oe[i];
      end
    end
    // Fourth port-A line (bit 3) exists only in 8-bit width
    porta_pin_out[3] = gpio_a_out[3];
    porta_pin_oe[3]  = gpio_a_oe[3] & cfg_reg.pa_func[PA_WIDTH];
    if (!cfg_reg.pc_func[PIN_TX]) begin
      portc_pin_out[3] = serial_tx;
      portc_pin_oe[3]  = 1'b1;
    end else begin
      portc_pin_out[3] = gpio_c_out[3];
      portc_pin_oe[3]  = gpio_c_oe[3];
    end
  end

  assign porta_width_8 = cfg_reg.pa_func[PA_WIDTH];

  ////////////////////////////////////////////////////////////////////////////
  // Bus access and register file
  assign addr_phase = hsel & htrans[1] & hready;
  assign a_index    = haddr[9:2];

  always_comb begin
    rd_val = 8'h00;
    case (a_index)
      IDX_T1_CTRL:  rd_val = cfg_reg.t1_ctrl;
      IDX_T1_CLK:   rd_val = cfg_reg.t1_clk;
      IDX_T2_CTRL:  rd_val = cfg_reg.t2_ctrl;
      IDX_T2_CLK:   rd_val = cfg_reg.t2_clk;
      IDX_PA_FUNC:  rd_val = cfg_reg.pa_func;
      IDX_PC_FUNC:  rd_val = cfg_reg.pc_func;
      IDX_T0_STATE: rd_val = {6'h00, timer0_out_of_reset_flag,
                              timer0_running_flag};
      IDX_T1_STATE: rd_val = {6'h00, cfg_reg.t1_ctrl[CTRL_RST_N],
                              cfg_reg.t1_ctrl[CTRL_RUN]};
      IDX_T2_STATE: rd_val = {6'h00, cfg_reg.t2_ctrl[CTRL_RST_N],
                              cfg_reg.t2_ctrl[CTRL_RUN]};
      IDX_IRQ_STAT: rd_val = {6'h00, cfg_reg.irq_stat};
      IDX_IRQ_MASK: rd_val = {6'h00, cfg_reg.irq_mask};
      IDX_T1_CMP:   rd_val = cfg_reg.t1_cmp;
      IDX_T2_CMP:   rd_val = cfg_reg.t2_cmp;
      default:      rd_val = 8'h00;
    endcase
  end

  always_comb begin
    cfg_next          = cfg_reg;
    cfg_next.dp_write = addr_phase & hwrite;
    if (addr_phase) begin
      cfg_next.dp_index = a_index;
      cfg_next.rdata    = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end
    // Read of the status register clears it; a new event in that cycle wins
    if (addr_phase && !hwrite && a_index == IDX_IRQ_STAT) begin
      cfg_next.irq_stat = 2'h0;
    end
    if (cfg_reg.dp_write) begin
      case (cfg_reg.dp_index)
        IDX_T1_CTRL: cfg_next.t1_ctrl  = hwdata[7:0] & CTRL_USED;
        IDX_T1_CLK:  cfg_next.t1_clk   = hwdata[7:0] & CLK_USED;
        IDX_T2_CTRL: cfg_next.t2_ctrl  = hwdata[7:0] & CTRL_USED;
        IDX_T2_CLK:  cfg_next.t2_clk   = hwdata[7:0] & CLK_USED;
        IDX_PA_FUNC: cfg_next.pa_func  = hwdata[7:0] & PIN_USED;
        IDX_PC_FUNC: cfg_next.pc_func  = hwdata[7:0] & PIN_USED;
        IDX_IRQ_MASK: cfg_next.irq_mask = hwdata[1:0];
        IDX_T1_CMP:  cfg_next.t1_cmp   = hwdata[7:0];
        IDX_T2_CMP:  cfg_next.t2_cmp   = hwdata[7:0];
        default: ;
      endcase
    end
    cfg_next.irq_stat = cfg_next.irq_stat | tmr_ev;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= '{dp_write: 1'b0, dp_index: 8'h00, rdata: 32'h0000_0000,
                   t1_ctrl: RST_CTRL, t1_clk: RST_CLK, t2_ctrl: RST_CTRL,
                   t2_clk: RST_CLK, pa_func: RST_PA_FUNC, pc_func: RST_PC_FUNC,
                   t1_cmp: RST_CMP, t2_cmp: RST_CMP, irq_stat: 2'h0,
                   irq_mask: 2'h0};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = cfg_reg.rdata;
  assign irq       = |(cfg_reg.irq_stat & cfg_reg.irq_mask);
endmodule : tp_timer_cfg

// ### rtl/tp_pkg.sv
// Constants for the timer/PWM configuration and status block.
// Assumes one master clock and a word-per-register AHB-Lite map.
package tp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_T1_CTRL   = 8'h08;
  localparam logic [7:0] IDX_T1_CLK    = 8'h09;
  localparam logic [7:0] IDX_T2_CTRL   = 8'h0a;
  localparam logic [7:0] IDX_T2_CLK    = 8'h0b;
  localparam logic [7:0] IDX_PA_FUNC   = 8'h0c;
  localparam logic [7:0] IDX_T0_STATE  = 8'h0d;
  localparam logic [7:0] IDX_T1_STATE  = 8'h0f;
  localparam logic [7:0] IDX_PC_FUNC   = 8'h10;
  localparam logic [7:0] IDX_T2_STATE  = 8'h11;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h14;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h15;
  localparam logic [7:0] IDX_T1_CMP    = 8'h16;
  localparam logic [7:0] IDX_T2_CMP    = 8'h17;
  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_RST_N  = 0;
  localparam int CTRL_RUN    = 2;
  localparam int CTRL_EDGE   = 4;
  localparam int CTRL_SRC    = 6;
  localparam int CTRL_PWM    = 7;
  localparam logic [7:0] CTRL_USED = 8'hf5;
  // Clock register fields
  localparam int CLK_DIV     = 0;
  localparam int CLK_SQUARE  = 5;
  localparam logic [7:0] CLK_USED  = 8'h3f;
  localparam logic [4:0] DIV_MAX   = 5'h10;
  // Pin function fields
  localparam int PIN_TX      = 3;
  localparam int PA_WIDTH    = 3;
  localparam logic [7:0] PIN_USED  = 8'h0f;
  // Status fields
  localparam int ST_RUN      = 0;
  localparam int ST_OUT_RST  = 1;
  // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter maximum
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_CLK     = 8'h00;
  localparam logic [7:0] RST_PA_FUNC = 8'h00;
  localparam logic [7:0] RST_PC_FUNC = 8'h0f;
  localparam logic [7:0] RST_CMP     = 8'h80;
  localparam logic [7:0] CNT_MAX     = 8'hff;
  // Timer unit states
  typedef enum logic [1:0] {
    TP_IDLE,
    TP_COUNT,
    TP_HELD
  } tp_state_e;
endpackage : tp_pkg

// ### rtl/tp_timer_unit.sv
// One timer/PWM unit: power-of-two prescaler, 8-bit counter, output, event.
// Assumes its control inputs come straight from registers on sys_clk.
`timescale 1ns/100ps
module tp_timer_unit
  import tp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       soft_reset_n,
  input  wire logic       soft_run,
  input  wire logic       pwm_select,
  input  wire logic       square_wave_sel,
  input  wire logic [1:0] irq_edge_sel,
  input  wire logic       irq_source_sel,
  input  wire logic [4:0] divider_code,
  input  wire logic [7:0] compare,
  output logic            timer_output,
  output logic            irq_event
);
  import tp_pkg::*;

  typedef struct packed {
    tp_state_e  state;
    logic [15:0] pre;
    logic [7:0]  cnt;
    logic        out;
    logic        ev;
  } tp_unit_s;

  tp_unit_s    st_reg;
  tp_unit_s    st_next;
  logic [4:0]  code;
  logic [15:0] mask;
  logic        tick;
  logic        stop_ev;

  always_comb begin
    code    = (divider_code > DIV_MAX) ? DIV_MAX : divider_code;
    mask    = 16'((17'h1 << code) - 17'h1);
    tick    = ((st_reg.pre & mask) == mask);
    stop_ev = 1'b0;
    st_next = st_reg;
    st_next.ev = 1'b0;
    if (!soft_reset_n) begin
      st_next.state = TP_IDLE;
      st_next.pre   = 16'h0000;
      st_next.cnt   = 8'h00;
      st_next.out   = 1'b0;
    end else begin
      case (st_reg.state)
        TP_IDLE: begin
          if (soft_run) begin
            st_next.state = TP_COUNT;
            st_next.pre   = 16'h0000;
            st_next.cnt   = 8'h00;
            st_next.out   = 1'b1;
          end
        end
        TP_COUNT: begin
          if (!soft_run) begin
            st_next.state = TP_IDLE;
          end else if (tick) begin
            st_next.pre = 16'h0000;
            st_next.cnt = st_reg.cnt + 8'h01;
            if (st_reg.cnt == compare) begin
              st_next.out = square_wave_sel ? ~st_reg.out : 1'b0;
              if (!pwm_select) begin
                st_next.state = TP_HELD;
                stop_ev       = 1'b1;
              end
            end
            if (pwm_select && st_reg.cnt == CNT_MAX) begin
              st_next.cnt = 8'h00;
              if (!square_wave_sel) begin
                st_next.out = 1'b1;
              end
            end
          end else begin
            st_next.pre = st_reg.pre + 16'h0001;
          end
        end
        TP_HELD: begin
          if (!soft_run) begin
            st_next.state = TP_IDLE;
          end
        end
        default: st_next.state = TP_IDLE;
      endcase
    end
    // Start drives the output high, so a rising-edge source also fires there
    if (irq_source_sel) begin
      case (irq_edge_sel)
        EDGE_FALL: st_next.ev = st_reg.out & ~st_next.out;
        EDGE_RISE: st_next.ev = ~st_reg.out & st_next.out;
        EDGE_BOTH: st_next.ev = st_reg.out ^ st_next.out;
        default:   st_next.ev = 1'b0;
      endcase
    end else begin
      st_next.ev = stop_ev;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{state: TP_IDLE, pre: 16'h0000, cnt: 8'h00, out: 1'b0, ev: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign timer_output = st_reg.out;
  assign irq_event    = st_reg.ev;
endmodule : tp_timer_unit

// ### sim/tp_timer_cfg_chk.sv
// Checker for tp_timer_cfg: pin routing, status reads, timer start, interrupt gate.
// Assumes binding to tp_timer_cfg; shadows the writes seen on its AHB-Lite ports.
`timescale 1ns/100ps
module tp_timer_cfg_chk
  import tp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic [3:0]        gpio_a_out,
  input wire logic [3:0]        gpio_a_oe,
  input wire logic [3:0]        gpio_c_out,
  input wire logic              serial_tx,
  input wire logic [3:0]        porta_pin_out,
  input wire logic [3:0]        porta_pin_oe,
  input wire logic [3:0]        portc_pin_out,
  input wire logic [3:0]        portc_pin_oe,
  input wire logic              porta_width_8,
  input wire logic              timer1_output,
  input wire logic              irq
);
  logic              wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [7:0]        pa_reg, pc_reg, c1_reg, mask_reg;
  logic              acc;
  assign acc = hsel & htrans[1] & hready;
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : hit
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the registers that steer pins and the interrupt
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      pa_reg      <= RST_PA_FUNC;
      pc_reg      <= RST_PC_FUNC;
      c1_reg      <= RST_CTRL;
      mask_reg    <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= acc & hwrite;
      wr_addr_reg <= haddr;
      if (wr_pend_reg && hit(wr_addr_reg, IDX_PA_FUNC)) pa_reg <= hwdata[7:0];
      if (wr_pend_reg && hit(wr_addr_reg, IDX_PC_FUNC)) pc_reg <= hwdata[7:0];
      if (wr_pend_reg && hit(wr_addr_reg, IDX_T1_CTRL)) c1_reg <= hwdata[7:0];
      if (wr_pend_reg && hit(wr_addr_reg, IDX_IRQ_MASK)) mask_reg <= hwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_pa_gpio;
    !pa_reg[0] |-> porta_pin_out[0] == gpio_a_out[0] && porta_pin_oe[0] == gpio_a_oe[0];
  endproperty
  a_pa_gpio: assert property (p_pa_gpio) else $error("port A line 0 not GPIO");
  property p_pa_route;
    pa_reg[1] && c1_reg[0] |-> porta_pin_out[1] == timer1_output && porta_pin_oe[1];
  endproperty
  a_pa_route: assert property (p_pa_route) else $error("timer 1 not on port A");
  property p_t1_reset_pin;
    pa_reg[1] && !c1_reg[0] |-> !porta_pin_oe[1];
  endproperty
  a_t1_reset_pin: assert property (p_t1_reset_pin) else $error("pin driven in reset");
  property p_width;
    porta_width_8 == pa_reg[3] && (pa_reg[3] || !porta_pin_oe[3]);
  endproperty
  a_width: assert property (p_width) else $error("port A width wrong");
  property p_pc_route;
    !pc_reg[1] && c1_reg[0] |-> portc_pin_out[1] == timer1_output && portc_pin_oe[1];
  endproperty
  a_pc_route: assert property (p_pc_route) else $error("timer 1 not on port C");
  property p_pc_gpio;
    pc_reg[2] |-> portc_pin_out[2] == gpio_c_out[2];
  endproperty
  a_pc_gpio: assert property (p_pc_gpio) else $error("port C line 2 not GPIO");
  property p_pc_tx;
    !pc_reg[3] |-> portc_pin_out[3] == serial_tx;
  endproperty
  a_pc_tx: assert property (p_pc_tx) else $error("serial transmit not on pin");
  property p_t1_start;
    $rose(c1_reg[2]) && c1_reg[0] |-> ##[1:2] timer1_output;
  endproperty
  a_t1_start: assert property (p_t1_start) else $error("timer 1 did not start");
  property p_t1_state;
    acc && !hwrite && hit(haddr, IDX_T1_STATE) |=>
      hrdata == {30'h0, $past(c1_reg[0]), $past(c1_reg[2])};
  endproperty
  a_t1_state: assert property (p_t1_state) else $error("timer 1 status wrong");
  property p_irq_mask;
    mask_reg[1:0] == 2'b00 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
endmodule : tp_timer_cfg_chk

bind tp_timer_cfg tp_timer_cfg_chk #(.ADDR_W(ADDR_W)) i_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .gpio_a_out(gpio_a_out), .gpio_a_oe(gpio_a_oe), .gpio_c_out(gpio_c_out),
  .serial_tx(serial_tx), .porta_pin_out(porta_pin_out), .porta_pin_oe(porta_pin_oe),
  .portc_pin_out(portc_pin_out), .portc_pin_oe(portc_pin_oe),
  .porta_width_8(porta_width_8), .timer1_output(timer1_output), .irq(irq));

// ### sim/testbench.sv
// Self-checking bench for tp_timer_cfg: map, status, routing, timing, interrupts.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
module testbench;
  import tp_pkg::*;
  logic        sys_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, seen;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        t0_out, t0_run, t0_live, serial_tx, pa_w8, t1_out, t2_out;
  logic [3:0]  ga_out, ga_oe, gc_out, gc_oe, pa_out, pa_oe, pc_out, pc_oe;
  int          miscompares = 0, checks = 0, cycles = 0, n;
  int          codes [4] = '{0, 1, 3, 6};
  logic [7:0]  ridx [10] = '{IDX_T1_CTRL, IDX_T1_CLK, IDX_T2_CTRL, IDX_T2_CLK, IDX_PA_FUNC,
                             IDX_PC_FUNC, IDX_T1_STATE, IDX_T2_STATE, IDX_T0_STATE, 8'h30};
  logic [7:0]  rval [10] = '{RST_CTRL, RST_CLK, RST_CTRL, RST_CLK, RST_PA_FUNC, RST_PC_FUNC,
                             8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wval [10] = '{CTRL_USED, CLK_USED, CTRL_USED, CLK_USED, PIN_USED, PIN_USED,
                             8'h03, 8'h03, 8'h01, 8'h00};
  logic [7:0]  ictl [4] = '{8'h41, 8'h51, 8'h61, 8'h01};
  logic [7:0]  early [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0]  late [4] = '{8'h01, 8'h00, 8'h01, 8'h01};

  tp_timer_cfg #(.ADDR_W(12)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_output(t0_out),
    .timer0_running_flag(t0_run), .timer0_out_of_reset_flag(t0_live),
    .serial_tx(serial_tx), .gpio_a_out(ga_out), .gpio_a_oe(ga_oe), .gpio_c_out(gc_out),
    .gpio_c_oe(gc_oe), .porta_pin_out(pa_out), .porta_pin_oe(pa_oe),
    .portc_pin_out(pc_out), .portc_pin_oe(pc_oe), .porta_width_8(pa_w8),
    .timer1_output(t1_out), .timer2_output(t2_out), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // Address phase held until hready, then the data phase until hready
  task automatic ahb_xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {2'b00, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb_xfer
  task automatic ahb_wr(input logic [7:0] idx, input logic [7:0] d);
    ahb_xfer(idx, 1'b1, d);
  endtask : ahb_wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    ahb_xfer(idx, 1'b0, 8'h00);
    check($sformatf("register %0h", idx), {24'h0, exp}, rd);
    check("response", 32'h0, {31'h0, hresp});
  endtask : rd_chk
  // Restart timer 1 and count cycles until its output has been high and fallen
  task automatic run_t1(input logic [7:0] ctl);
    // Reset and run move together, as software must do in PWM mode
    ahb_wr(IDX_T1_CTRL, ctl & 8'hfa);
    ahb_wr(IDX_T1_CTRL, ctl | 8'h05);
    n = 0;
    seen = 1'b0;
    while (!(seen && t1_out === 1'b0) && n < 70000) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (t1_out === 1'b1) seen = 1'b1;
    end
  endtask : run_t1

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    {t0_out, t0_run, t0_live, serial_tx} = 4'h0;
    {ga_out, ga_oe, gc_out, gc_oe} = 16'hadc3;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (ridx[i]) rd_chk(ridx[i], rval[i]);
    t0_run <= 1'b1;
    foreach (ridx[i]) ahb_wr(ridx[i], 8'hff);
    foreach (ridx[i]) rd_chk(ridx[i], wval[i]);
    #1;
    check("width select", 32'h1, {31'h0, pa_w8});
    check("port C gpio", {28'h0, gc_out}, {28'h0, pc_out});
    ahb_wr(IDX_T1_CTRL, 8'h00);
    t0_live <= 1'b1;
    t0_out <= 1'b1;
    serial_tx <= 1'b1;
    #1;
    check("pin drive in reset", 32'h0, {31'h0, pa_oe[1]});
    ahb_wr(IDX_PC_FUNC, 8'h00);
    #1;
    check("timer 0 on port A", 32'h3, {30'h0, pa_oe[0], pa_out[0]});
    check("port C routed", 32'h9, {28'h0, pc_out[3], 2'b00, pc_out[0]});
    ahb_wr(IDX_PA_FUNC, 8'h00);
    #1;
    check("port A gpio", {24'h0, ga_out, 1'b0, ga_oe[2:0]}, {24'h0, pa_out, pa_oe});
    ahb_wr(IDX_T1_CMP, 8'h08);
    foreach (codes[i]) begin
      ahb_wr(IDX_T1_CLK, 8'(codes[i]));
      run_t1(8'h01);
      checks++;
      // Compare 8 counted from 0 is nine prescaled ticks, plus the start edge
      if (n != (9 << codes[i]) + 1) begin
        miscompares++;
        $display("unexpected high time: expected %0d, seen %0d", (9 << codes[i]) + 1, n);
      end
    end
    repeat (300) @(posedge sys_clk);
    check("held low", 32'h0, {31'h0, t1_out});
    ahb_wr(IDX_T1_CLK, 8'h00);
    ahb_wr(IDX_T1_CMP, 8'h40);
    ahb_wr(IDX_IRQ_MASK, 8'h01);
    foreach (ictl[i]) begin
      ahb_wr(IDX_T1_CTRL, ictl[i]);
      ahb_xfer(IDX_IRQ_STAT, 1'b0, 8'h00);
      ahb_wr(IDX_T1_CTRL, ictl[i] | 8'h04);
      repeat (4) @(posedge sys_clk);
      rd_chk(IDX_IRQ_STAT, early[i]);
      n = 0;
      while (t1_out !== 1'b0 && n < 300) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      check("output fell", 32'h0, {31'h0, t1_out});
      repeat (3) @(posedge sys_clk);
      #1;
      check("irq level", {24'h0, late[i]}, {31'h0, irq});
      rd_chk(IDX_IRQ_STAT, late[i]);
      #1;
      check("irq cleared", 32'h0, {31'h0, irq});
    end
    ahb_wr(IDX_T1_CMP, 8'h10);
    run_t1(8'h81);
    n = 0;
    while (t1_out !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("pwm wraps high", 32'h1, {31'h0, t1_out});
    // Timer 2, timer mode, code 1, compare 4: five ticks of two cycles high
    ahb_wr(IDX_T2_CTRL, 8'h00);
    ahb_wr(IDX_T2_CLK, 8'h01);
    ahb_wr(IDX_T2_CMP, 8'h04);
    ahb_wr(IDX_T2_CTRL, 8'h05);
    n = 0;
    seen = 1'b0;
    while (!(seen && t2_out === 1'b0) && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (t2_out === 1'b1) seen = 1'b1;
    end
    check("timer 2 high time", 32'd11, n);
    repeat (2) @(posedge sys_clk);
    #1;
    check("masked irq", 32'h0, {31'h0, irq});
    rd_chk(IDX_IRQ_STAT, 8'h02);
    wrap_up();
  end
endmodule : testbench
